// ==== src/mpf_pin_select.sv ====
// Pin function select for the bridge's miscellaneous terminals.
//
// Overview of operation
// RULE1 - Clock-run support is off when the clock run strap is 0, on when 1.
// RULE2 - External arbiter strap 0 selects the internal arbiter, 1 an external one.
// RULE3 - Pin 0 is the clock run input in clock run mode, else a general pin.
// RULE4 - Each general pin n in GPIO mode takes its direction from bit n of the GPIO control register.
// RULE5 - Pin 1 is the power override output when field 22:20 is 001b or 011b.
// RULE6 - Pin 2 must be high at reset release to enable 1.0a compatibility mode.
// RULE7 - Pin 4 is the serial clock when a pull-up is seen on serial data, else GPIO.
// RULE8 - Pin 5 is serial data when a pull-up is seen on it, else GPIO.
// RULE9 - With an external arbiter, request 0 is the bridge's own grant.
// RULE10 - Straps and pull detection are latched at reset release and held until reset.
`timescale 1ns/100ps
module mpf_pin_select (
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   // AXI4-Lite write address and data
   input  wire logic                s_axi_awvalid_i,
   output logic                     s_axi_awready_o,
   input  wire logic [7:0]          s_axi_awaddr_i,
   input  wire logic                s_axi_wvalid_i,
   output logic                     s_axi_wready_o,
   input  wire logic [31:0]         s_axi_wdata_i,
   input  wire logic [3:0]          s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic                     s_axi_bvalid_o,
   input  wire logic                s_axi_bready_i,
   output logic [1:0]               s_axi_bresp_o,
   // AXI4-Lite read
   input  wire logic                s_axi_arvalid_i,
   output logic                     s_axi_arready_o,
   input  wire logic [7:0]          s_axi_araddr_i,
   output logic                     s_axi_rvalid_o,
   input  wire logic                s_axi_rready_i,
   output logic [31:0]              s_axi_rdata_o,
   output logic [1:0]               s_axi_rresp_o,
   // Strap inputs
   input  wire logic                clock_run_strap_i,
   input  wire logic                external_arbiter_strap_i,
   // General-purpose pins, three signals each
   input  wire logic [7:0]          general_pin_i,
   output logic [7:0]               general_pin_o,
   output logic [7:0]               general_pin_oe_o,
   // Inner functions sharing the pins
   input  wire logic                power_override_value_i,
   input  wire logic                scl_drive_low_i,
   input  wire logic                sda_drive_low_i,
   output logic                     clock_run_pin_o,
   output logic                     scl_in_o,
   output logic                     sda_in_o,
   // Arbitration
   input  wire logic                request0_i,
   output logic                     arbiter_request0_o,
   output logic                     bridge_grant_o,
   // Latched modes
   output mpf_pkg::mpf_strap_t      modes_o
);
   import mpf_pkg::*;

   function automatic logic pwr_selected(input logic [2:0] code);
      return (code == MPF_PWR_CODE_A) || (code == MPF_PWR_CODE_B);
   endfunction

   // Latched straps.
   mpf_strap_t modes_reg, modes_next;
   logic       captured_reg, captured_next;

   // Registers.
   logic [7:0] dir_reg, dir_next;
   logic [7:0] data_reg, data_next;
   logic [2:0] pwr_reg, pwr_next;

   // Bus state.
   logic        aw_have_reg, aw_have_next;
   logic        w_have_reg, w_have_next;
   logic [7:0]  aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0]  w_strb_reg, w_strb_next;
   logic        awready_reg, awready_next;
   logic        wready_reg, wready_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        arready_reg, arready_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;

   // Pin outputs.
   logic [7:0] pin_out_reg, pin_out_next;
   logic [7:0] pin_oe_reg, pin_oe_next;
   logic       clock_run_pin_reg, clock_run_pin_next;
   logic       scl_reg, scl_next;
   logic       sda_reg, sda_next;
   logic       req0_reg, req0_next;
   logic       grant_reg, grant_next;

   // Straps are caught on the first edge after release, with every pin
   // still undriven so that only the board's pull sets the level.
   always_comb begin
      modes_next    = modes_reg;
      captured_next = 1'b1;
      if (!captured_reg) begin
         modes_next.clock_run        = clock_run_strap_i;        // RULE1 RULE10
         modes_next.external_arbiter = external_arbiter_strap_i; // RULE2 RULE10
         modes_next.compat_mode = general_pin_i[MPF_PIN_COMPAT]; // RULE6
         modes_next.serial_bus  = general_pin_i[MPF_PIN_SDA];    // RULE7 RULE8
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         modes_reg    <= MPF_STRAP_RST;
         captured_reg <= 1'b0;
      end else begin
         modes_reg    <= modes_next;
         captured_reg <= captured_next;
      end
   end

   // Bus slave: one write and one read at a time, address and data
   // accepted in either order.
   always_comb begin
      logic [31:0] wmask;
      logic [31:0] gen_word;
      wmask        = '0;
      gen_word     = '0;
      dir_next     = dir_reg;
      data_next    = data_reg;
      pwr_next     = pwr_reg;
      aw_have_next = aw_have_reg;
      w_have_next  = w_have_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      if (bvalid_reg && s_axi_bready_i)
         bvalid_next = 1'b0;
      if (s_axi_awvalid_i && awready_reg) begin
         aw_have_next = 1'b1;
         aw_addr_next = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_reg) begin
         w_have_next = 1'b1;
         w_data_next = s_axi_wdata_i;
         w_strb_next = s_axi_wstrb_i;
      end
      if (aw_have_next && w_have_next && !bvalid_next) begin
         for (int i = 0; i < 4; i++)
            wmask[i*8 +: 8] = {8{w_strb_next[i]}};
         gen_word = {9'h000, pwr_reg, 20'h00000};
         gen_word = (gen_word & ~wmask) | (w_data_next & wmask);
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = MPF_RESP_OKAY;
         case ({aw_addr_next[7:2], 2'b00})
            MPF_GPIO_DIR_OFS:
               if (w_strb_next[0])
                  dir_next = w_data_next[7:0];
            MPF_GPIO_DATA_OFS:
               if (w_strb_next[0])
                  data_next = w_data_next[7:0];
            MPF_GEN_CTRL_OFS:
               pwr_next = gen_word[MPF_PWR_FIELD_MSB:MPF_PWR_FIELD_LSB];
            MPF_STATUS_OFS: ;
            default:
               bresp_next = MPF_RESP_SLVERR;
         endcase
      end
      if (rvalid_reg && s_axi_rready_i)
         rvalid_next = 1'b0;
      if (s_axi_arvalid_i && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = MPF_RESP_OKAY;
         case ({s_axi_araddr_i[7:2], 2'b00})
            MPF_GPIO_DIR_OFS:  rdata_next = {24'h000000, dir_reg};
            MPF_GPIO_DATA_OFS: rdata_next = {24'h000000, general_pin_i};
            MPF_GEN_CTRL_OFS:  rdata_next = {9'h000, pwr_reg, 20'h00000};
            MPF_STATUS_OFS:    rdata_next = {28'h0000000, modes_reg};
            default: begin
               rdata_next = '0;
               rresp_next = MPF_RESP_SLVERR;
            end
         endcase
      end
      awready_next = !aw_have_next && !bvalid_next;
      wready_next  = !w_have_next && !bvalid_next;
      arready_next = !rvalid_next;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         dir_reg     <= MPF_DIR_RST;
         data_reg    <= MPF_DATA_RST;
         pwr_reg     <= MPF_PWR_RST;
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= MPF_RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= MPF_RESP_OKAY;
      end else begin
         dir_reg     <= dir_next;
         data_reg    <= data_next;
         pwr_reg     <= pwr_next;
         aw_have_reg <= aw_have_next;
         w_have_reg  <= w_have_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   // Pin function selection. Nothing drives a pin before the straps are
   // latched, otherwise the device would sample its own drive.
   always_comb begin
      pin_out_next = data_reg;
      pin_oe_next  = captured_reg ? dir_reg : '0;                // RULE4
      if (modes_reg.clock_run) begin
         pin_oe_next[MPF_PIN_CLOCK_RUN_PIN] = 1'b0;                     // RULE3
      end
      if (pwr_selected(pwr_reg) && captured_reg) begin
         pin_out_next[MPF_PIN_PWR] = power_override_value_i;     // RULE5
         pin_oe_next[MPF_PIN_PWR]  = 1'b1;                       // RULE5
      end
      if (modes_reg.serial_bus) begin
         pin_out_next[MPF_PIN_SCL] = 1'b0;                       // RULE7
         pin_oe_next[MPF_PIN_SCL]  = scl_drive_low_i;            // RULE7
         pin_out_next[MPF_PIN_SDA] = 1'b0;                       // RULE8
         pin_oe_next[MPF_PIN_SDA]  = sda_drive_low_i;            // RULE8
      end
      // Idle high is the deasserted clock run level.
      clock_run_pin_next = modes_reg.clock_run ?
                    general_pin_i[MPF_PIN_CLOCK_RUN_PIN] : 1'b1;        // RULE3
      scl_next = modes_reg.serial_bus ?
                 general_pin_i[MPF_PIN_SCL] : 1'b1;
      sda_next = modes_reg.serial_bus ?
                 general_pin_i[MPF_PIN_SDA] : 1'b1;
      req0_next  = modes_reg.external_arbiter ? 1'b0 : request0_i; // RULE9
      grant_next = modes_reg.external_arbiter ? request0_i : 1'b0; // RULE9
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_out_reg <= '0;
         pin_oe_reg  <= '0;
         clock_run_pin_reg  <= 1'b1;
         scl_reg     <= 1'b1;
         sda_reg     <= 1'b1;
         req0_reg    <= 1'b0;
         grant_reg   <= 1'b0;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg  <= pin_oe_next;
         clock_run_pin_reg  <= clock_run_pin_next;
         scl_reg     <= scl_next;
         sda_reg     <= sda_next;
         req0_reg    <= req0_next;
         grant_reg   <= grant_next;
      end
   end

   assign s_axi_awready_o    = awready_reg;
   assign s_axi_wready_o     = wready_reg;
   assign s_axi_bvalid_o     = bvalid_reg;
   assign s_axi_bresp_o      = bresp_reg;
   assign s_axi_arready_o    = arready_reg;
   assign s_axi_rvalid_o     = rvalid_reg;
   assign s_axi_rdata_o      = rdata_reg;
   assign s_axi_rresp_o      = rresp_reg;
   assign general_pin_o      = pin_out_reg;
   assign general_pin_oe_o   = pin_oe_reg;
   assign clock_run_pin_o    = clock_run_pin_reg;
   assign scl_in_o           = scl_reg;
   assign sda_in_o           = sda_reg;
   assign arbiter_request0_o = req0_reg;
   assign bridge_grant_o     = grant_reg;
   assign modes_o            = modes_reg;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_first_edge;
      !captured_reg ##1 captured_reg;
   endsequence

   a_clock_run_pin_strap_latch: assert property ( // RULE1
      s_first_edge |-> modes_reg.clock_run == $past(clock_run_strap_i))
      else $error("clock run mode not latched from strap");

   a_arb_strap_latch: assert property ( // RULE2
      s_first_edge |->
         modes_reg.external_arbiter == $past(external_arbiter_strap_i))
      else $error("arbiter mode not latched from strap");

   // The pin outputs lag the mode by one cycle, so the mode must already
   // have stood a cycle before the clock run level is compared.
   a_clock_run_pin_pin_input: assert property ( // RULE3
      ##1 modes_reg.clock_run && $past(modes_reg.clock_run) |->
         !general_pin_oe_o[MPF_PIN_CLOCK_RUN_PIN] &&
         clock_run_pin_o == $past(general_pin_i[MPF_PIN_CLOCK_RUN_PIN]))
      else $error("pin 0 not acting as clock run input");

   a_gpio_direction: assert property ( // RULE4
      ##1 captured_reg && !modes_reg.clock_run && !modes_reg.serial_bus &&
         !pwr_selected(pwr_reg) && $stable(dir_reg) |=>
         general_pin_oe_o == $past(dir_reg))
      else $error("pin direction differs from control register");

   a_power_override: assert property ( // RULE5
      captured_reg && pwr_selected(pwr_reg) |=>
         general_pin_oe_o[MPF_PIN_PWR] &&
         general_pin_o[MPF_PIN_PWR] == $past(power_override_value_i))
      else $error("pin 1 not driving power override");

   a_compat_latch: assert property ( // RULE6
      s_first_edge |->
         modes_reg.compat_mode == $past(general_pin_i[MPF_PIN_COMPAT]))
      else $error("compatibility mode not latched from pin 2");

   a_serial_clock: assert property ( // RULE7
      modes_reg.serial_bus |=>
         general_pin_oe_o[MPF_PIN_SCL] == $past(scl_drive_low_i) &&
         !general_pin_o[MPF_PIN_SCL])
      else $error("pin 4 not acting as serial clock");

   a_serial_data: assert property ( // RULE8
      s_first_edge ##0 modes_reg.serial_bus |=>
         general_pin_oe_o[MPF_PIN_SDA] == $past(sda_drive_low_i))
      else $error("pin 5 not acting as serial data");

   a_grant_route: assert property ( // RULE9
      modes_reg.external_arbiter |=>
         bridge_grant_o == $past(request0_i) && !arbiter_request0_o)
      else $error("request 0 not routed as grant");

   a_modes_hold: assert property ( // RULE10
      captured_reg |=> $stable(modes_reg))
      else $error("latched modes changed before reset");

endmodule // mpf_pin_select

// ==== src/mpf_pkg.sv ====
// Package for the miscellaneous pin function select block.
package mpf_pkg;

   // Register byte offsets.
   localparam logic [7:0] MPF_GPIO_DIR_OFS  = 8'h00;
   localparam logic [7:0] MPF_GPIO_DATA_OFS = 8'h04;
   localparam logic [7:0] MPF_GEN_CTRL_OFS  = 8'h08;
   localparam logic [7:0] MPF_STATUS_OFS    = 8'h0c;

   // Field layout of the general control register.
   localparam int MPF_PWR_FIELD_LSB = 20;
   localparam int MPF_PWR_FIELD_MSB = 22;

   // Power override codes that turn pin 1 into the override output.
   localparam logic [2:0] MPF_PWR_CODE_A = 3'h1;
   localparam logic [2:0] MPF_PWR_CODE_B = 3'h3;

   // Pin positions with a second function.
   localparam int MPF_PIN_CLOCK_RUN_PIN = 0;
   localparam int MPF_PIN_PWR    = 1;
   localparam int MPF_PIN_COMPAT = 2;
   localparam int MPF_PIN_SCL    = 4;
   localparam int MPF_PIN_SDA    = 5;

   // Reset values.
   localparam logic [7:0]  MPF_DIR_RST  = 8'h00;
   localparam logic [7:0]  MPF_DATA_RST = 8'h00;
   localparam logic [2:0]  MPF_PWR_RST  = 3'h0;

   // AXI responses.
   localparam logic [1:0] MPF_RESP_OKAY   = 2'h0;
   localparam logic [1:0] MPF_RESP_SLVERR = 2'h2;

   // Levels latched once at reset release.
   typedef struct packed {
      logic compat_mode;
      logic serial_bus;
      logic external_arbiter;
      logic clock_run;
   } mpf_strap_t;

   localparam mpf_strap_t MPF_STRAP_RST = '0;

endpackage

// ==== test/mpf_board_model.sv ====
// Board model: pull resistors and external logic on the general pins.
`timescale 1ns/100ps
module mpf_board_model (
   // Design side of the pins
   input  wire logic [7:0] pin_out_i,
   input  wire logic [7:0] pin_oe_i,
   // External system logic and pull choice
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   input  wire logic       sda_pull_up_i,
   // Resolved pin levels
   output logic      [7:0] pin_level_o
);
   logic [7:0] pull;

   // Pin 5 pull picks the serial mode; the others have pull-ups.
   assign pull = {2'h3, sda_pull_up_i, 5'h1f};

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_i[i]) begin
            pin_level_o[i] = pin_out_i[i];
         end else if (ext_en_i[i]) begin
            pin_level_o[i] = ext_val_i[i];
         end else begin
            pin_level_o[i] = pull[i];
         end
      end
   end
endmodule // mpf_board_model

// ==== test/mpf_pin_select_tb.sv ====
// Self-checking bench for the pin function select block.
`timescale 1ns/100ps
module mpf_pin_select_tb;
   import mpf_pkg::*;
   logic        clock_i, rst_i;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, resp;
   logic        cr_strap, ea_strap, pov, scl_low, sda_low, req0;
   logic [7:0]  pin_o, pin_oe, level, ext_en, ext_val;
   logic        sda_pu, cr_pin, scl_in, sda_in, arb_req, grant;
   logic [31:0] rd;
   mpf_strap_t  modes;
   int          num_errors, checks_done;

   mpf_pin_select dut_u (.clock_i(clock_i), .rst_i(rst_i),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .clock_run_strap_i(cr_strap),
      .external_arbiter_strap_i(ea_strap), .general_pin_i(level),
      .general_pin_o(pin_o), .general_pin_oe_o(pin_oe),
      .power_override_value_i(pov), .scl_drive_low_i(scl_low),
      .sda_drive_low_i(sda_low), .clock_run_pin_o(cr_pin),
      .scl_in_o(scl_in), .sda_in_o(sda_in), .request0_i(req0),
      .arbiter_request0_o(arb_req), .bridge_grant_o(grant),
      .modes_o(modes));

   mpf_board_model board_u (.pin_out_i(pin_o), .pin_oe_i(pin_oe),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .sda_pull_up_i(sda_pu),
      .pin_level_o(level));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic complete_run();
      $display("Errors %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic hang(input int n);
      if (n > 50) begin
         num_errors++;
         $display("[ERR] bus wait expected answer seen none");
         complete_run();
      end
   endtask

   // Address and data go out together; each is dropped once taken.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock_i);
         n++;
         hang(n);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clock_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock_i);
         n++;
         hang(n);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      resp = rresp;
      rd = rdata;
      rready <= 1'b0;
   endtask

   task automatic do_reset(input logic cr, input logic ea,
                           input logic pu, input logic p2);
      @(posedge clock_i);
      rst_i <= 1'b1;
      cr_strap <= cr;
      ea_strap <= ea;
      sda_pu <= pu;
      ext_val <= {5'h0, p2, 2'h0};
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask

   // Outputs follow their causes one cycle later; three leaves margin.
   task automatic settle();
      repeat (3) @(posedge clock_i);
   endtask

   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      {cr_strap, ea_strap, pov, scl_low, sda_low, req0, sda_pu} = '0;
      ext_en = 8'h04;
      ext_val = 8'h00;
      num_errors = 0;
      checks_done = 0;
      rst_i = 1'b1;
      // Plain mode: every strap low, pin 5 pulled down, pin 2 held low.
      do_reset(1'b0, 1'b0, 1'b0, 1'b0);
      chk("modes", 32'h0, 32'(modes));
      chk("clock run pin", 32'h1, 32'(cr_pin));
      req0 <= 1'b1;
      settle();
      chk("arb request", 32'h1, 32'(arb_req));
      chk("grant", 32'h0, 32'(grant));
      axi_write(MPF_GPIO_DIR_OFS, 32'h5a);
      axi_write(MPF_GPIO_DATA_OFS, 32'hc3);
      settle();
      chk("oe", 32'h5a, 32'(pin_oe));
      chk("out", 32'h42, 32'(pin_o & 8'h5a));
      axi_read(MPF_GPIO_DATA_OFS);
      chk("levels", 32'hc3, rd);
      axi_read(MPF_GPIO_DIR_OFS);
      chk("dir", 32'h5a, rd);
      // Pin 1 as an input, so only the override can drive it; a low
      // override value tells the drive apart from the pull-up.
      axi_write(MPF_GPIO_DIR_OFS, 32'h58);
      pov <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         axi_write(MPF_GEN_CTRL_OFS, 32'(c) << MPF_PWR_FIELD_LSB);
         settle();
         chk("pin1 oe", 32'(c == 1 || c == 3), 32'(pin_oe[1]));
         chk("pin1 level", 32'(!(c == 1 || c == 3)), 32'(level[1]));
      end
      axi_read(8'h10);
      chk("unmapped rresp", 32'(MPF_RESP_SLVERR), 32'(resp));
      axi_write(8'h10, 32'h1);
      chk("unmapped bresp", 32'(MPF_RESP_SLVERR), 32'(resp));
      // Every strap high, pin 5 pulled up, pin 2 held high.
      do_reset(1'b1, 1'b1, 1'b1, 1'b1);
      chk("modes", 32'hf, 32'(modes));
      settle();
      chk("arb request", 32'h0, 32'(arb_req));
      chk("grant", 32'h1, 32'(grant));
      axi_write(MPF_GPIO_DIR_OFS, 32'hff);
      ext_en <= 8'h01;
      scl_low <= 1'b1;
      settle();
      chk("pin0 oe", 32'h0, 32'(pin_oe[0]));
      chk("clock run pin", 32'h0, 32'(cr_pin));
      chk("scl level", 32'h0, 32'(level[4]));
      chk("scl in", 32'h0, 32'(scl_in));
      chk("sda level", 32'h1, 32'(level[5]));
      chk("sda in", 32'h1, 32'(sda_in));
      // Straps moving after release must not change the latched modes.
      {cr_strap, ea_strap, sda_pu} <= 3'h0;
      ext_en <= 8'h04;
      ext_val <= 8'h00;
      settle();
      chk("held modes", 32'hf, 32'(modes));
      axi_read(MPF_STATUS_OFS);
      chk("status", 32'hf, rd);
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      num_errors++;
      $display("[ERR] run length expected end seen limit");
      complete_run();
   end
endmodule // mpf_pin_select_tb
